// >>> bench/fdl_assertions.sv
/*
  Checker for one link board: APB answers and cable events.
  Assumes it is bound to fdl_top.
*/
`timescale 1ns/1ns
module fdl_assertions
  import fdl_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              irq,
  input wire fdl_pkg::fdl_link_t peer_in,
  input wire fdl_pkg::fdl_link_t link_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ********
  // Sequences
  // ********
  sequence cmd_wr;
    psel && penable && pready && pwrite && paddr == FDL_OFF_CMD;
  endsequence
  sequence tx_go;
    cmd_wr ##0 pwdata[3:2] == 2'h1;
  endsequence
  sequence quiet;
    $stable(link_out.tx_start) && $stable(link_out.wr) && $stable(link_out.rx_clear) && $stable(link_out.rx_start_busy);
  endsequence
  // ********
  // Properties
  // ********
  // Cable toggles trail the command by the registered command stage, hence the window
  ans_due_a: assert property (psel && !penable |-> ##2 pready) else $error("setup not answered");
  ans_once_a: assert property (pready |=> !pready) else $error("answer too long");
  err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > FDL_OFF_CFG))
    else $error("wrong error answer");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
  tx_word_a: assert property (tx_go |-> ##[1:4] ($changed(link_out.wr) && link_out.tx_busy))
    else $error("word not sent");
  tx_peer_a: assert property (tx_go |-> ##[1:4] $changed(link_out.tx_start)) else $error("no start event");
  rx_free_a: assert property (cmd_wr ##0 (pwdata[1:0] == 2'h2 || pwdata[4]) |-> ##[1:4] $changed(link_out.rx_clear))
    else $error("peer not freed");
  rx_again_a: assert property (cmd_wr ##0 (pwdata[1:0] == 2'h1 && link_out.rx_busy)
    |-> ##[1:4] $changed(link_out.rx_start_busy)) else $error("restart not sent");
  pulse_idle_a: assert property (cmd_wr ##0 pwdata[4:0] == 5'h0f |=> quiet [*3]) else $error("pulse acted");
  tx_local_a: assert property (cmd_wr ##0 pwdata[4:0] == 5'h08 |=> quiet [*4]) else $error("clear reached peer");
endmodule

bind fdl_top fdl_assertions fdl_assertions_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .irq, .peer_in, .link_out);

// >>> bench/fdl_peer.sv
/*
  Peer board model: answers our cable toggles, offers host tasks.
  Assumes toggle events and level flags on fdl_link_t.
*/
`timescale 1ns/1ns
module fdl_peer
  import fdl_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire fdl_pkg::fdl_link_t from_dut,
  output fdl_pkg::fdl_link_t     to_dut
);
  fdl_link_t   last;
  logic        rx_done;
  logic        tx_done;
  logic [15:0] got;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_dut  <= '0;
      last    <= '0;
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      got     <= 16'h0;
    end else begin
      last <= from_dut;
      if (from_dut.rx_clear != last.rx_clear || from_dut.rx_start_busy != last.rx_start_busy) begin
        tx_done        <= to_dut.tx_busy;
        to_dut.tx_busy <= 1'b0;
      end
      if (from_dut.wr != last.wr) begin
        got <= from_dut.wdata;
      end
      if (from_dut.tx_start != last.tx_start && to_dut.rx_busy) begin
        rx_done <= 1'b1;
      end
    end
  end
  task automatic send(input logic [15:0] d);
    @(posedge pclk);
    to_dut.wdata    <= d;
    to_dut.wr       <= ~to_dut.wr;
    to_dut.tx_start <= ~to_dut.tx_start;
    to_dut.tx_busy  <= 1'b1;
    tx_done         <= 1'b0;
  endtask
  task automatic rx_start();
    @(posedge pclk);
    if (to_dut.rx_busy) begin
      to_dut.rx_start_busy <= ~to_dut.rx_start_busy;
    end
    to_dut.rx_busy <= 1'b1;
    rx_done        <= from_dut.tx_busy;
  endtask
  task automatic rd_clear();
    @(posedge pclk);
    to_dut.rx_clear <= ~to_dut.rx_clear;
    to_dut.rx_busy  <= 1'b0;
    rx_done         <= 1'b0;
  endtask
endmodule

// >>> bench/fdl_top_bench.sv
/*
  Self-checking bench: one link board against the peer model.
  Assumes fdl_top, fdl_peer and the bound checker.
*/
`timescale 1ns/1ns
module fdl_top_bench;
  import fdl_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        erv;
  fdl_link_t   peer_in;
  fdl_link_t   link_out;
  int          bad_count = 0;
  int          checks = 0;
  logic [15:0] w;
  always #4 pclk = ~pclk;
  fdl_top fdl_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .peer_in, .link_out);
  fdl_peer fdl_peer_i (.pclk, .presetn, .from_dut(link_out), .to_dut(peer_in));
  // ********
  // Tasks
  // ********
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the rising edge that sees pready high; the answer is taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t bus hang", $time);
      wrap_up();
    end
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic cmd(input logic [4:0] c);
    apb(1'b1, FDL_OFF_CMD, {27'h0, c});
  endtask
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask
  function automatic logic [31:0] fl(input logic rb, input logic rdn, input logic tb, input logic tdn);
    return {28'h0, tdn, tb, rdn, rb};
  endfunction
  function automatic logic [31:0] ptx();
    return {30'h0, fdl_peer_i.to_dut.tx_busy, fdl_peer_i.tx_done};
  endfunction
  // ********
  // Main sequence
  // ********
  initial begin
    void'($urandom(32'hcaf03654));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(FDL_OFF_FLAGS, 32'h0);
    rd(FDL_OFF_IRQMSK, 32'h0);
    rd(FDL_OFF_CFG, 32'h1);
    rd(FDL_OFF_RXDATA, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, erv}, 32'h1);
    apb(1'b1, 12'h020, 32'h5);
    chk({31'h0, erv}, 32'h1);
    $display("test reset and map done");
    apb(1'b1, FDL_OFF_IRQMSK, 32'h3);
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom);
      cmd(5'h01);
      rd(FDL_OFF_FLAGS, fl(1, 0, 0, 0));
      fdl_peer_i.send(w);
      settle();
      rd(FDL_OFF_FLAGS, fl(1, 1, 0, 0));
      rd(FDL_OFF_RXDATA, {16'h0, w});
      chk({31'h0, irq}, 32'h1);
      cmd(5'h10);
      settle();
      rd(FDL_OFF_FLAGS, 32'h0);
      chk(ptx(), 32'h1);
      apb(1'b1, FDL_OFF_IRQST, 32'h1);
      rd(FDL_OFF_IRQST, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    $display("test receive done");
    fdl_peer_i.send(16'($urandom));
    settle();
    cmd(5'h01);
    rd(FDL_OFF_FLAGS, fl(1, 1, 0, 0));
    cmd(5'h01);
    settle();
    chk(ptx(), 32'h1);
    cmd(5'h02);
    settle();
    rd(FDL_OFF_FLAGS, 32'h0);
    chk(ptx(), 32'h0);
    cmd(5'h01);
    rd(FDL_OFF_FLAGS, fl(1, 0, 0, 0));
    cmd(5'h0f);
    rd(FDL_OFF_FLAGS, fl(1, 0, 0, 0));
    cmd(5'h02);
    settle();
    apb(1'b1, FDL_OFF_IRQST, 32'h3);
    $display("test pending and pulse done");
    for (int i = 0; i < 3; i++) begin
      w = 16'($urandom);
      fdl_peer_i.rx_start();
      apb(1'b1, FDL_OFF_TXDATA, {16'h0, w});
      cmd(5'h04);
      rd(FDL_OFF_FLAGS, fl(0, 0, 1, 0));
      settle();
      chk({16'h0, fdl_peer_i.got}, {16'h0, w});
      chk({31'h0, fdl_peer_i.rx_done}, 32'h1);
      rd(FDL_OFF_FLAGS, fl(0, 0, 1, 0));
      fdl_peer_i.rd_clear();
      settle();
      rd(FDL_OFF_FLAGS, fl(0, 0, 0, 1));
      rd(FDL_OFF_IRQST, 32'h2);
      apb(1'b1, FDL_OFF_IRQST, 32'h2);
    end
    cmd(5'h08);
    rd(FDL_OFF_FLAGS, 32'h0);
    $display("test transmit done");
    apb(1'b1, FDL_OFF_IRQMSK, 32'h0);
    w = 16'($urandom);
    fdl_peer_i.send(w);
    cmd(5'h01);
    settle();
    chk({31'h0, irq}, 32'h0);
    rd(FDL_OFF_IRQST, 32'h1);
    apb(1'b1, FDL_OFF_IRQMSK, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    cmd(5'h10);
    apb(1'b1, FDL_OFF_IRQST, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    $display("test mask done");
    apb(1'b1, FDL_OFF_CFG, 32'h0);
    rd(FDL_OFF_CFG, 32'h0);
    fdl_peer_i.send(~w);
    settle();
    rd(FDL_OFF_RXDATA, {16'h0, w});
    apb(1'b1, FDL_OFF_CFG, 32'h1);
    fdl_peer_i.send(~w);
    settle();
    rd(FDL_OFF_RXDATA, {16'h0, ~w});
    $display("test storage end done");
    wrap_up();
  end
endmodule

// >>> src/fdl_flags.sv
/*
  Flag engine of one board: receive and transmit Busy/Done and the held word.
  Takes decoded local commands and synchronised peer cable events.
  Assumes events are one-cycle pulses on pclk.
*/
`timescale 1ns/1ns
module fdl_flags
  import fdl_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire fdl_pkg::fdl_cmd_t     cmd,
  input  wire logic                  right_end,
  input  wire logic                  peer_tx_start,
  input  wire logic                  peer_rx_start_busy,
  input  wire logic                  peer_rx_clear,
  input  wire logic                  peer_tx_busy,
  input  wire logic                  peer_wr,
  input  wire logic [FDL_WORD_W-1:0] peer_wdata,
  output fdl_pkg::fdl_flags_t        rx,
  output fdl_pkg::fdl_flags_t        tx,
  output logic      [FDL_WORD_W-1:0] held
);
  typedef struct packed {
    fdl_flags_t            rx;
    fdl_flags_t            tx;
    logic [FDL_WORD_W-1:0] held;
  } fdl_flags_st_t;

  fdl_flags_st_t st;
  fdl_flags_st_t next_st;
  logic          rx_start;
  logic          rx_clear;

  always_comb begin
    next_st  = st;
    rx_start = cmd.rx_fn == FDL_FN_START;
    rx_clear = (cmd.rx_fn == FDL_FN_CLEAR) || cmd.rd;
    // ************************************************************
    // Local commands first, peer effects after: fixed order
    // ************************************************************
    if (rx_start) begin
      next_st.rx = '{busy: 1'b1, done: 1'b0};
      if (peer_tx_busy) begin
        next_st.rx.done = 1'b1;
      end
    end else if (rx_clear) begin
      next_st.rx = '{busy: 1'b0, done: 1'b0};
    end
    if (cmd.tx_fn == FDL_FN_START) begin
      next_st.tx = '{busy: 1'b1, done: 1'b0};
    end else if (cmd.tx_fn == FDL_FN_CLEAR) begin
      next_st.tx = '{busy: 1'b0, done: 1'b0};
    end
    // Pulse function is decoded but changes nothing
    if (peer_tx_start && next_st.rx.busy) begin
      next_st.rx.done = 1'b1;
    end
    if (peer_rx_start_busy || peer_rx_clear) begin
      next_st.tx.done = st.tx.busy;
      next_st.tx.busy = 1'b0;
    end
    // Only the right end stores; the left keeps its held word and drops the arriving one
    if (peer_wr && right_end) begin
      next_st.held = peer_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{rx: '0, tx: '0, held: FDL_WORD_RST};
    end else begin
      st <= next_st;
    end
  end

  assign rx   = st.rx;
  assign tx   = st.tx;
  assign held = st.held;
endmodule

// >>> src/fdl_pkg.sv
/*
  Package for the full-duplex word link: register offsets, field positions,
  reset values, command encodings and the carrier structs shared by the files.
  Assumes one system clock pclk and an APB register bus with 32-bit data.
*/
package fdl_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [11:0] FDL_OFF_CMD    = 12'h000;
  localparam logic [11:0] FDL_OFF_TXDATA = 12'h004;
  localparam logic [11:0] FDL_OFF_RXDATA = 12'h008;
  localparam logic [11:0] FDL_OFF_FLAGS  = 12'h00c;
  localparam logic [11:0] FDL_OFF_IRQST  = 12'h010;
  localparam logic [11:0] FDL_OFF_IRQMSK = 12'h014;
  localparam logic [11:0] FDL_OFF_CFG    = 12'h018;

  // ************************************************************
  // Field positions
  // ************************************************************
  // Command register: bits [1:0] receive function, [3:2] transmit function,
  // bit 4 read-with-clear of the held word.
  localparam int FDL_CMD_RX_LSB  = 0;
  localparam int FDL_CMD_TX_LSB  = 2;
  localparam int FDL_CMD_RDC_BIT = 4;
  // Flag register holds busy and done per channel; interrupt registers hold only the two done bits.
  localparam int FDL_FLG_RX_BUSY = 0;
  localparam int FDL_FLG_RX_DONE = 1;
  localparam int FDL_FLG_TX_BUSY = 2;
  localparam int FDL_FLG_TX_DONE = 3;
  localparam int FDL_IRQ_RX_DONE = 0;
  localparam int FDL_IRQ_TX_DONE = 1;
  localparam int FDL_CFG_RIGHT   = 0;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int          FDL_WORD_W    = 16;
  localparam int          FDL_IRQ_W     = 2;
  localparam logic [15:0] FDL_WORD_RST  = 16'h0000;
  localparam logic [1:0]  FDL_MASK_RST  = 2'h0;
  localparam logic        FDL_RIGHT_RST = 1'b1;

  // ************************************************************
  // Channel functions
  // ************************************************************
  typedef enum logic [1:0] {
    FDL_FN_NONE  = 2'h0,
    FDL_FN_START = 2'h1,
    FDL_FN_CLEAR = 2'h2,
    FDL_FN_PULSE = 2'h3
  } fdl_fn_t;

  typedef struct packed {
    logic busy;
    logic done;
  } fdl_flags_t;

  // Command toward one board: functions plus data strobe.
  typedef struct packed {
    fdl_fn_t               rx_fn;
    fdl_fn_t               tx_fn;
    logic                  wr;
    logic [FDL_WORD_W-1:0] wdata;
    logic                  rd;
  } fdl_cmd_t;

  // Cable bundle each board drives toward its peer.
  typedef struct packed {
    logic                  tx_start;
    logic                  rx_start_busy;
    logic                  rx_clear;
    logic                  rx_busy;
    logic                  tx_busy;
    logic                  wr;
    logic [FDL_WORD_W-1:0] wdata;
  } fdl_link_t;

  typedef enum logic [2:0] {
    FDL_APB_IDLE   = 3'b001,
    FDL_APB_SETUP  = 3'b010,
    FDL_APB_ACCESS = 3'b100
  } fdl_apb_st_t;

endpackage

// >>> src/fdl_sync.sv
/*
  Two-stage synchroniser for a bundle of level signals from the cable.
  Assumes the peer board runs on an unrelated clock.
*/
`timescale 1ns/1ns
module fdl_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fdl_sync_st_t;

  fdl_sync_st_t st;
  fdl_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule

// >>> src/fdl_top.sv
/*
  Full-duplex word link, one board: APB slave, command decode, cable
  interface to the peer board and interrupt logic.
  Assumes the peer board is an identical copy whose cable outputs feed
  the peer_* inputs; cable inputs are asynchronous and are synchronised.
*/
// The address map and register access over APB were chosen for this implementation.
// Functional notes
// - Words of 16 bits pass both ways, one transmit and one receive channel per side.
// - A transmitted word lands in the peer receive holding buffer.
// - The sender sees transmit done only after the receiver clears, reads with clear or restarts receive while busy.
// - Receive start sets busy 1 done 0, and if busy was set frees the peer transmitter.
// - Receive clear zeros local receive flags and frees the peer transmitter.
// - A pulse function on either channel changes nothing.
// - Transmit start sets busy 1 done 0 and marks the peer receive done if it waits.
// - Transmit clear zeros local transmit flags only.
// - Receive done rises at once after start if a word is pending, else when it arrives.
// - An arriving word leaves receive busy set.
// - Read with clear returns the word and gives the peer transmitter busy 0 done 1.
// - Write with start sends the word and sets transmit busy 1 done 0.
// - Flags are readable and the done flags raise an interrupt.
// - Only the right end stores words; the left end keeps its held word unchanged.
`timescale 1ns/1ns
module fdl_top
  import fdl_pkg::*;
(
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [11:0]                    paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  output logic                                irq,
  input  wire fdl_pkg::fdl_link_t             peer_in,
  output fdl_pkg::fdl_link_t                  link_out
);
  import fdl_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    fdl_apb_st_t           apb;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    fdl_link_t             link;
    fdl_cmd_t              cmd;
    logic [FDL_WORD_W-1:0] txword;
    logic [FDL_IRQ_W-1:0]  irq_st;
    logic [FDL_IRQ_W-1:0]  irq_msk;
    logic                  right_end;
    logic [1:0]            done_q;
  } fdl_top_st_t;

  fdl_top_st_t st;
  fdl_top_st_t next_st;

  fdl_link_t             peer;
  fdl_flags_t            rx;
  fdl_flags_t            tx;
  logic [FDL_WORD_W-1:0] held;
  logic                  wr_acc;
  logic [FDL_IRQ_W-1:0]  irq_set;
  logic [1:0]            done_now;
  logic                  peer_start_p;
  logic                  peer_rsb_p;
  logic                  peer_clr_p;
  logic                  peer_wr_p;

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    return addr_hit(a, FDL_OFF_CMD) || addr_hit(a, FDL_OFF_TXDATA) || addr_hit(a, FDL_OFF_RXDATA) ||
           addr_hit(a, FDL_OFF_FLAGS) || addr_hit(a, FDL_OFF_IRQST) || addr_hit(a, FDL_OFF_IRQMSK) ||
           addr_hit(a, FDL_OFF_CFG);
  endfunction

  // ************************************************************
  // Cable inputs
  // ************************************************************
  // Events arrive as toggles so that a slow peer pulse is never missed
  fdl_sync #(
    .W ($bits(fdl_link_t))
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (peer_in),
    .q       (peer)
  );

  typedef struct packed {
    logic start;
    logic rsb;
    logic clr;
    logic wr;
  } fdl_tog_t;

  fdl_tog_t tog_q;
  fdl_tog_t next_tog_q;

  always_comb begin
    next_tog_q = '{start: peer.tx_start, rsb: peer.rx_start_busy, clr: peer.rx_clear, wr: peer.wr};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= '0;
    end else begin
      tog_q <= next_tog_q;
    end
  end

  assign peer_start_p = peer.tx_start ^ tog_q.start;
  assign peer_rsb_p   = peer.rx_start_busy ^ tog_q.rsb;
  assign peer_clr_p   = peer.rx_clear ^ tog_q.clr;
  // The word leaves a cycle ahead of its toggle, so it is settled when the toggle is seen
  assign peer_wr_p    = peer.wr ^ tog_q.wr;

  fdl_flags u_flags (
    .pclk               (pclk),
    .presetn            (presetn),
    .cmd                (st.cmd),
    .right_end          (st.right_end),
    .peer_tx_start      (peer_start_p),
    .peer_rx_start_busy (peer_rsb_p),
    .peer_rx_clear      (peer_clr_p),
    .peer_tx_busy       (peer.tx_busy),
    .peer_wr            (peer_wr_p),
    .peer_wdata         (peer.wdata),
    .rx                 (rx),
    .tx                 (tx),
    .held               (held)
  );

  // ************************************************************
  // Bus, commands and interrupts
  // ************************************************************
  always_comb begin
    next_st         = st;
    next_st.cmd     = '0;
    next_st.pready  = 1'b0;
    next_st.pslverr = 1'b0;
    wr_acc          = 1'b0;
    done_now        = {tx.done, rx.done};
    irq_set         = done_now & ~st.done_q;
    next_st.done_q  = done_now;

    case (st.apb)
      FDL_APB_IDLE: begin
        if (psel && !penable) begin
          next_st.apb = FDL_APB_SETUP;
        end
      end
      FDL_APB_SETUP: begin
        next_st.apb     = FDL_APB_ACCESS;
        next_st.pready  = 1'b1;
        next_st.pslverr = !addr_known(paddr);
        next_st.prdata  = 32'h0000_0000;
        if (!pwrite) begin
          if (addr_hit(paddr, FDL_OFF_RXDATA)) begin
            next_st.prdata = {16'h0000, held};
          end else if (addr_hit(paddr, FDL_OFF_FLAGS)) begin
            next_st.prdata = {28'h0000000, tx.done, tx.busy, rx.done, rx.busy};
          end else if (addr_hit(paddr, FDL_OFF_IRQST)) begin
            next_st.prdata = {30'h00000000, st.irq_st};
          end else if (addr_hit(paddr, FDL_OFF_IRQMSK)) begin
            next_st.prdata = {30'h00000000, st.irq_msk};
          end else if (addr_hit(paddr, FDL_OFF_CFG)) begin
            next_st.prdata = {31'h00000000, st.right_end};
          end else if (addr_hit(paddr, FDL_OFF_TXDATA)) begin
            next_st.prdata = {16'h0000, st.txword};
          end
        end
      end
      FDL_APB_ACCESS: begin
        // Write takes effect at the edge that sees pready high
        wr_acc      = psel && penable && pwrite;
        next_st.apb = (psel && !penable) ? FDL_APB_SETUP : FDL_APB_IDLE;
      end
      default: begin
        next_st.apb = FDL_APB_IDLE;
      end
    endcase

    if (wr_acc && addr_hit(paddr, FDL_OFF_TXDATA)) begin
      next_st.txword = pwdata[FDL_WORD_W-1:0];
    end
    if (wr_acc && addr_hit(paddr, FDL_OFF_CMD)) begin
      next_st.cmd.rx_fn = fdl_fn_t'(pwdata[FDL_CMD_RX_LSB+:2]);
      next_st.cmd.tx_fn = fdl_fn_t'(pwdata[FDL_CMD_TX_LSB+:2]);
      next_st.cmd.rd    = pwdata[FDL_CMD_RDC_BIT];
      next_st.cmd.wr    = pwdata[FDL_CMD_TX_LSB+:2] == FDL_FN_START;
    end
    if (wr_acc && addr_hit(paddr, FDL_OFF_IRQMSK)) begin
      next_st.irq_msk = pwdata[FDL_IRQ_W-1:0];
    end
    if (wr_acc && addr_hit(paddr, FDL_OFF_CFG)) begin
      next_st.right_end = pwdata[FDL_CFG_RIGHT];
    end
    // Set wins over a write-one clear in the same cycle
    next_st.irq_st = st.irq_st;
    if (wr_acc && addr_hit(paddr, FDL_OFF_IRQST)) begin
      next_st.irq_st = st.irq_st & ~pwdata[FDL_IRQ_W-1:0];
    end
    next_st.irq_st = next_st.irq_st | irq_set;
    next_st.irq    = |(next_st.irq_st & next_st.irq_msk);

    // Cable events are toggles; level flags follow the local state
    if (st.cmd.tx_fn == FDL_FN_START) begin
      next_st.link.tx_start = !st.link.tx_start;
    end
    if (next_st.cmd.wr) begin
      next_st.link.wdata = st.txword;
    end
    if (st.cmd.wr) begin
      next_st.link.wr = !st.link.wr;
    end
    if (st.cmd.rx_fn == FDL_FN_START && rx.busy) begin
      next_st.link.rx_start_busy = !st.link.rx_start_busy;
    end
    if (st.cmd.rx_fn == FDL_FN_CLEAR || st.cmd.rd) begin
      next_st.link.rx_clear = !st.link.rx_clear;
    end
    next_st.link.rx_busy = rx.busy;
    // Raised with the start toggle and then held by the flag, so the level never dips
    next_st.link.tx_busy = st.cmd.tx_fn == FDL_FN_START ? 1'b1 : tx.busy;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.apb       <= FDL_APB_IDLE;
      st.irq_msk   <= FDL_MASK_RST;
      st.right_end <= FDL_RIGHT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign irq      = st.irq;
  assign link_out = st.link;
endmodule
